//--- hdl/secrc_pkg.sv
package secrc_pkg;

    // Arbitrary value, not tied to any real part
    localparam logic [3:0] DEV_TYPE_CODE = 4'h5;

    localparam int          ADDR_W       = 16;
    localparam int          MEM_AW       = 12;
    localparam int          ARRAY_BYTES  = 4096;
    localparam int          CACHE_AW     = 6;
    localparam int          PAGE_AW      = 3;
    localparam int          FIFO_W       = 8;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          PAGE_TIME_MS = 5;
    localparam int          CLK_HZ       = 100_000_000;
    localparam int          PAGE_CYCLES  = PAGE_TIME_MS * (CLK_HZ / 1000);
    localparam int          TIMER_W      = 20;
    localparam logic [7:0]  UNUSED_DATA  = 8'hff;
    localparam logic [3:0]  BIT_LAST     = 4'h8;
    localparam logic [3:0]  BIT_ACK      = 4'h9;
    localparam logic [15:0] PTR_RST      = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_CTRL    = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_WDATA   = 3'b100,
        ST_RDATA   = 3'b101,
        ST_COMMIT  = 3'b110,
        ST_WAIT    = 3'b111
    } secrc_state_type;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } secrc_wr_type;

    function automatic logic secrc_in_array(input logic [ADDR_W-1:0] a);
        secrc_in_array = (a < 16'(ARRAY_BYTES));
    endfunction : secrc_in_array

endpackage : secrc_pkg

//--- hdl/secrc_fifo.sv
module secrc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic [WIDTH-1:0]      o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count_reg != (AW + 1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data  = store_reg[rd_reg];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always_comb begin
        wr_next    = push ? wr_reg + 1'b1 : wr_reg;
        rd_next    = pop ? rd_reg + 1'b1 : rd_reg;
        count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            count_reg <= '0;
        end else begin
            wr_reg    <= wr_next;
            rd_reg    <= rd_next;
            count_reg <= count_next;
        end
        if (push) begin
            store_reg[wr_reg] <= i_in_data;
        end
    end

endmodule : secrc_fifo

//--- hdl/secrc_array.sv
module secrc_array
    import secrc_pkg::*;
(
    input  wire logic                     i_clk,
    input  wire secrc_pkg::secrc_wr_type  i_wr,
    input  wire logic [secrc_pkg::ADDR_W-1:0] i_rd_addr,
    output logic [7:0]                    o_rd_data
);
    logic [7:0] cell_reg [ARRAY_BYTES];
    logic [7:0] rd_next;

    always_comb begin
        rd_next = secrc_in_array(i_rd_addr) ? cell_reg[i_rd_addr[MEM_AW-1:0]] : UNUSED_DATA;
    end

    always_ff @(posedge i_clk) begin
        o_rd_data <= rd_next;
        if (i_wr.en && secrc_in_array(i_wr.addr)) begin
            cell_reg[i_wr.addr[MEM_AW-1:0]] <= i_wr.data;
        end
    end

endmodule : secrc_array

//--- hdl/secrc_top.sv
module secrc_top
    import secrc_pkg::*;
#(
    parameter int P_PAGE_CYCLES = secrc_pkg::PAGE_CYCLES
) (
    input  wire logic       I_CLK,
    input  wire logic       I_RESET_N,
    input  wire logic       I_SCL,
    input  wire logic       I_SDA,
    output logic            O_SDA_OUT,
    output logic            O_SDA_OE,
    input  wire logic [2:0] I_CHIP_SELECT,
    output logic            O_BUSY,
    output logic            O_STANDBY
);
    import secrc_pkg::*;

    // Two-flop synchronisers, third stage for edges
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [2:0] cs_meta_reg;
    logic [2:0] cs_sync_reg;
    logic       scl_old_reg;
    logic       sda_old_reg;
    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            cs_meta_reg  <= 3'h0;
            cs_sync_reg  <= 3'h0;
            scl_old_reg  <= 1'b1;
            sda_old_reg  <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], I_SCL};
            sda_sync_reg <= {sda_sync_reg[0], I_SDA};
            cs_meta_reg  <= I_CHIP_SELECT;
            cs_sync_reg  <= cs_meta_reg;
            scl_old_reg  <= scl_sync_reg[1];
            sda_old_reg  <= sda_sync_reg[1];
        end
    end

    assign scl      = scl_sync_reg[1];
    assign sda      = sda_sync_reg[1];
    assign scl_rise = scl & ~scl_old_reg;
    assign scl_fall = ~scl & scl_old_reg;
    assign bus_start = scl & scl_old_reg & ~sda & sda_old_reg;
    assign bus_stop  = scl & scl_old_reg & sda & ~sda_old_reg;

    // Protocol state
    secrc_state_type          state_reg;
    secrc_state_type          state_next;
    logic [3:0]               bit_reg;
    logic [3:0]               bit_next;
    logic [7:0]               shift_reg;
    logic [7:0]               shift_next;
    logic [7:0]               tx_reg;
    logic [7:0]               tx_next;
    logic                     oe_reg;
    logic                     oe_next;
    logic [7:0]               addr_hi_reg;
    logic [7:0]               addr_hi_next;
    logic [ADDR_W-1:0]        ptr_reg;
    logic [ADDR_W-1:0]        ptr_next;
    logic [ADDR_W-1:0]        base_reg;
    logic [ADDR_W-1:0]        base_next;
    logic [CACHE_AW-1:0]      cidx_reg;
    logic [CACHE_AW-1:0]      cidx_next;
    logic [63:0]              valid_reg;
    logic [63:0]              valid_next;
    logic                     loaded_reg;
    logic                     loaded_next;
    logic [PAGE_AW-1:0]       pg_reg;
    logic [PAGE_AW-1:0]       pg_next;
    logic [PAGE_AW-1:0]       byte_reg;
    logic [PAGE_AW-1:0]       byte_next;
    logic [TIMER_W-1:0]       timer_reg;
    logic [TIMER_W-1:0]       timer_next;
    logic                     busy_reg;
    logic                     standby_reg;
    logic                     sda_low_reg;
    logic [7:0]               cache_reg [64];
    logic [7:0]               rd_data;
    logic                     push_valid;
    logic                     push_ready;
    logic [7:0]               pop_data;
    logic                     pop_valid;
    logic                     pop_ready;
    logic                     pop;
    logic [CACHE_AW-1:0]      slot;
    logic                     page_used;
    logic [12:0]              arr_page;
    secrc_wr_type             wr;

    secrc_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (I_CLK),
        .i_reset_n   (I_RESET_N),
        .i_in_data   (shift_reg),
        .i_in_valid  (push_valid),
        .o_in_ready  (push_ready),
        .o_out_data  (pop_data),
        .o_out_valid (pop_valid),
        .i_out_ready (pop_ready)
    );

    secrc_array u_array (
        .i_clk     (I_CLK),
        .i_wr      (wr),
        .i_rd_addr (ptr_reg),
        .o_rd_data (rd_data)
    );

    // Drain stalls only while a page programs
    assign pop_ready = (state_reg != ST_WAIT);
    assign pop       = pop_valid & pop_ready;
    assign slot      = {pg_reg, byte_reg};
    assign page_used = |valid_reg[{pg_reg, 3'h0} +: 8];
    assign arr_page  = base_reg[ADDR_W-1:PAGE_AW] + {10'h000, pg_reg};

    always_comb begin
        wr.en   = (state_reg == ST_COMMIT) && !pop_valid && valid_reg[slot];
        wr.addr = {arr_page, byte_reg};
        wr.data = cache_reg[slot];
    end

    always_comb begin
        state_next   = state_reg;
        bit_next     = bit_reg;
        shift_next   = shift_reg;
        tx_next      = tx_reg;
        oe_next      = oe_reg;
        addr_hi_next = addr_hi_reg;
        ptr_next     = ptr_reg;
        base_next    = base_reg;
        cidx_next    = cidx_reg;
        valid_next   = valid_reg;
        loaded_next  = loaded_reg;
        pg_next      = pg_reg;
        byte_next    = byte_reg;
        timer_next   = timer_reg;
        push_valid   = 1'b0;

        if (pop) begin
            valid_next[cidx_reg] = 1'b1;
            cidx_next            = cidx_reg + 1'b1;
        end

        case (state_reg)
            ST_COMMIT: begin
                oe_next = 1'b0;
                if (!pop_valid) begin
                    byte_next = byte_reg + 1'b1;
                    if (byte_reg == 3'h7) begin
                        if (page_used) begin
                            state_next = ST_WAIT;
                            timer_next = TIMER_W'(P_PAGE_CYCLES - 1);
                        end else if (pg_reg == 3'h7) begin
                            state_next = ST_IDLE;
                        end else begin
                            pg_next = pg_reg + 1'b1;
                        end
                    end
                end
            end
            ST_WAIT: begin
                oe_next    = 1'b0;
                timer_next = timer_reg - 1'b1;
                if (timer_reg == '0) begin
                    if (pg_reg == 3'h7) begin
                        state_next = ST_IDLE;
                    end else begin
                        pg_next    = pg_reg + 1'b1;
                        state_next = ST_COMMIT;
                    end
                end
            end
            default: begin
                if (bus_start) begin
                    state_next = ST_CTRL;
                    bit_next   = 4'h0;
                    oe_next    = 1'b0;
                end else if (bus_stop) begin
                    bit_next = 4'h0;
                    oe_next  = 1'b0;
                    if (state_reg == ST_WDATA && loaded_reg) begin
                        state_next = ST_COMMIT;
                        pg_next    = 3'h0;
                        byte_next  = 3'h0;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end else if (state_reg == ST_RDATA) begin
                    if (scl_rise && bit_reg < BIT_LAST) begin
                        bit_next = bit_reg + 1'b1;
                    end else if (scl_rise && bit_reg == BIT_LAST) begin
                        ptr_next = ptr_reg + 1'b1;
                        if (!sda) begin
                            bit_next = BIT_ACK;
                        end else begin
                            state_next = ST_IDLE;
                            bit_next   = 4'h0;
                        end
                    end else if (scl_fall && bit_reg == BIT_ACK) begin
                        oe_next  = ~rd_data[7];
                        tx_next  = {rd_data[6:0], 1'b0};
                        bit_next = 4'h0;
                    end else if (scl_fall && bit_reg == BIT_LAST) begin
                        oe_next = 1'b0;
                    end else if (scl_fall && bit_reg != 4'h0) begin
                        oe_next = ~tx_reg[7];
                        tx_next = {tx_reg[6:0], 1'b0};
                    end
                end else if (state_reg != ST_IDLE) begin
                    if (scl_rise && bit_reg < BIT_LAST) begin
                        shift_next = {shift_reg[6:0], sda};
                        bit_next   = bit_reg + 1'b1;
                    end else if (scl_fall && bit_reg == BIT_ACK) begin
                        oe_next  = 1'b0;
                        bit_next = 4'h0;
                        // First read bit follows control ack
                        if (state_reg == ST_RDATA) begin
                            oe_next = ~rd_data[7];
                            tx_next = {rd_data[6:0], 1'b0};
                        end
                    end else if (scl_fall && bit_reg == BIT_LAST) begin
                        bit_next = BIT_ACK;
                        oe_next  = 1'b1;
                        case (state_reg)
                            ST_CTRL: begin
                                if (shift_reg[7:4] != DEV_TYPE_CODE || shift_reg[3:1] != cs_sync_reg) begin
                                    state_next = ST_IDLE;
                                    oe_next    = 1'b0;
                                    bit_next   = 4'h0;
                                end else if (shift_reg[0]) begin
                                    state_next = ST_RDATA;
                                end else begin
                                    state_next = ST_ADDR_HI;
                                end
                            end
                            ST_ADDR_HI: begin
                                addr_hi_next = shift_reg;
                                state_next   = ST_ADDR_LO;
                            end
                            ST_ADDR_LO: begin
                                ptr_next    = {addr_hi_reg, shift_reg};
                                base_next   = {addr_hi_reg, shift_reg};
                                cidx_next   = {3'h0, shift_reg[2:0]};
                                valid_next  = 64'h0;
                                loaded_next = 1'b0;
                                state_next  = ST_WDATA;
                            end
                            default: begin
                                // Full buffer withholds ack
                                if (push_ready) begin
                                    push_valid  = 1'b1;
                                    loaded_next = 1'b1;
                                    ptr_next    = ptr_reg + 1'b1;
                                end else begin
                                    oe_next = 1'b0;
                                end
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            state_reg   <= ST_IDLE;
            bit_reg     <= 4'h0;
            shift_reg   <= 8'h00;
            tx_reg      <= 8'h00;
            oe_reg      <= 1'b0;
            addr_hi_reg <= 8'h00;
            ptr_reg     <= PTR_RST;
            base_reg    <= PTR_RST;
            cidx_reg    <= 6'h00;
            valid_reg   <= 64'h0;
            loaded_reg  <= 1'b0;
            pg_reg      <= 3'h0;
            byte_reg    <= 3'h0;
            timer_reg   <= '0;
            busy_reg    <= 1'b0;
            standby_reg <= 1'b1;
            sda_low_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            bit_reg     <= bit_next;
            shift_reg   <= shift_next;
            tx_reg      <= tx_next;
            oe_reg      <= oe_next;
            addr_hi_reg <= addr_hi_next;
            ptr_reg     <= ptr_next;
            base_reg    <= base_next;
            cidx_reg    <= cidx_next;
            valid_reg   <= valid_next;
            loaded_reg  <= loaded_next;
            pg_reg      <= pg_next;
            byte_reg    <= byte_next;
            timer_reg   <= timer_next;
            busy_reg    <= (state_next == ST_COMMIT) || (state_next == ST_WAIT);
            standby_reg <= (state_next == ST_IDLE) && !pop_valid;
            sda_low_reg <= 1'b0;
        end
        if (pop) begin
            cache_reg[cidx_reg] <= pop_data;
        end
    end

    assign O_SDA_OE  = oe_reg;
    assign O_SDA_OUT = sda_low_reg;
    assign O_BUSY    = busy_reg;
    assign O_STANDBY = standby_reg;

endmodule : secrc_top

//--- sim/secrc_assertions.sv
module secrc_assertions #(
    parameter int P_PAGE_CYCLES = 20
) (
    input wire logic       I_CLK,
    input wire logic       I_RESET_N,
    input wire logic       I_SCL,
    input wire logic       I_SDA,
    input wire logic       O_SDA_OUT,
    input wire logic       O_SDA_OE,
    input wire logic [2:0] I_CHIP_SELECT,
    input wire logic       O_BUSY,
    input wire logic       O_STANDBY
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BUSY_MAX = 8 * (P_PAGE_CYCLES + 8) + 4;
    logic [15:0] bcnt_reg, bcnt_next;
    logic [7:0]  age_reg, age_next;
    logic        sda_reg, sda_next;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    always_comb begin
        bcnt_next = O_BUSY ? bcnt_reg + 16'h0001 : 16'h0000;
        age_next  = (age_reg == 8'hff) ? 8'hff : age_reg + 8'h01;
        // Pin-level stop, ahead of the synchronisers
        if (I_SCL && I_SDA && !sda_reg) begin
            age_next = 8'h00;
        end
        sda_next = I_SDA;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            bcnt_reg <= 16'h0000;
            age_reg  <= 8'hff;
            sda_reg  <= 1'b1;
        end else begin
            bcnt_reg <= bcnt_next;
            age_reg  <= age_next;
            sda_reg  <= sda_next;
        end
    end

    a_sda_out_low: assert property (O_SDA_OUT == 1'b0)
        else $error("data driven high");
    a_no_ack_busy: assert property (O_BUSY |-> !O_SDA_OE)
        else $error("pull while busy");
    a_busy_not_standby: assert property (O_BUSY |-> !O_STANDBY)
        else $error("standby while busy");
    a_oe_scl_low: assert property ($changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL))
        else $error("data moved with clock high");
    a_busy_after_stop: assert property ($rose(O_BUSY) |-> age_reg < 8'h10)
        else $error("write cycle without stop");
    a_busy_min_time: assert property ($fell(O_BUSY) |-> bcnt_reg >= 16'(P_PAGE_CYCLES))
        else $error("write cycle too short");
    a_busy_max_time: assert property (bcnt_reg <= 16'(BUSY_MAX))
        else $error("write cycle too long");
    a_standby_after: assert property ($fell(O_BUSY) |-> ##[0:4] O_STANDBY)
        else $error("no standby after cycle");

    cover property ($rose(O_BUSY));
    cover property ($fell(O_BUSY));
    cover property ($rose(O_SDA_OE));
endmodule : secrc_assertions

bind secrc_top secrc_assertions #(.P_PAGE_CYCLES(P_PAGE_CYCLES)) u_chk (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_SCL(I_SCL), .I_SDA(I_SDA),
    .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .I_CHIP_SELECT(I_CHIP_SELECT),
    .O_BUSY(O_BUSY), .O_STANDBY(O_STANDBY)
);

//--- sim/secrc_master.sv
module secrc_master
    import secrc_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    // Ten cycles, above the synchroniser minimum
    task automatic half();
        repeat (10) @(negedge i_clk);
    endtask : half

    task automatic start();
        o_sda_low = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        o_sda_low = 1'b1;
        half();
        o_scl = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask : start

    task automatic stop();
        o_sda_low = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        o_sda_low = 1'b0;
        half();
    endtask : stop

    // Data set only while clock low
    task automatic bit_x(input logic b, output logic r);
        o_sda_low = !b;
        half();
        o_scl = 1'b1;
        half();
        r     = i_sda;
        o_scl = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask : bit_x

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask : wbyte

    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_x(1'b1, r);
            d = {d[6:0], r};
        end
        bit_x(!more, r);
    endtask : rbyte

    task automatic ctrl(input logic [14:0] a, input logic rd, output logic ack);
        wbyte({DEV_TYPE_CODE, a[14:12], rd}, ack);
    endtask : ctrl
endmodule : secrc_master

//--- sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import secrc_pkg::*;

    localparam int         PAGE_T = 40;
    localparam logic [2:0] SEL    = 3'h5;

    logic       clk, rst_n, scl, low, sda, sda_out, sda_oe, busy, standby;
    logic [2:0] cs;
    logic [7:0] exp_mem [int];
    int         bad_count, tests_run;

    // Pull-up wins unless a party pulls low
    assign sda = ((sda_oe && !sda_out) || low) ? 1'b0 : 1'b1;

    secrc_top #(.P_PAGE_CYCLES(PAGE_T)) dut (
        .I_CLK(clk), .I_RESET_N(rst_n), .I_SCL(scl), .I_SDA(sda),
        .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_CHIP_SELECT(cs),
        .O_BUSY(busy), .O_STANDBY(standby)
    );
    secrc_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(low));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    task automatic open_at(input logic [14:0] a);
        logic k;
        m.start();
        m.ctrl(a, 1'b0, k);
        check("ctrl ack", 8'(k), 8'h01);
        m.wbyte({4'h0, a[11:8]}, k);
        check("addr hi ack", 8'(k), 8'h01);
        m.wbyte(a[7:0], k);
        check("addr lo ack", 8'(k), 8'h01);
    endtask : open_at

    task automatic t_refuse();
        logic k;
        m.start();
        m.wbyte({DEV_TYPE_CODE, ~SEL, 1'b0}, k);
        check("wrong select", 8'(k), 8'h00);
        m.start();
        m.wbyte({DEV_TYPE_CODE ^ 4'h3, SEL, 1'b0}, k);
        check("wrong type", 8'(k), 8'h00);
        m.stop();
        step(4);
        check("standby", 8'(standby), 8'h01);
    endtask : t_refuse

    task automatic t_cache_write();
        logic k;
        int   n;
        open_at({SEL, 12'h7fa});
        for (int i = 0; i < 67; i++) begin
            m.wbyte(8'(i * 13 + 5), k);
            check("data ack", 8'(k), 8'h01);
            // Slot starts at low address bits and wraps at 64
            exp_mem[32'h7f8 + (2 + i) % 64] = 8'(i * 13 + 5);
        end
        m.stop();
        m.start();
        m.ctrl({SEL, 12'h000}, 1'b0, k);
        check("poll busy", 8'(k), 8'h00);
        m.stop();
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            step(1);
            n++;
        end
        check("busy end", 8'(busy), 8'h00);
        step(4);
        check("standby", 8'(standby), 8'h01);
        m.start();
        m.ctrl({SEL, 12'h000}, 1'b0, k);
        check("poll done", 8'(k), 8'h01);
        m.stop();
    endtask : t_cache_write

    task automatic t_partial();
        logic k;
        int   n;
        open_at({SEL, 12'h802});
        for (int i = 0; i < 3; i++) begin
            m.wbyte(8'ha0 + 8'(i), k);
            exp_mem[32'h802 + i] = 8'ha0 + 8'(i);
        end
        m.stop();
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        check("busy rise", 8'(busy), 8'h01);
        n = 0;
        while (busy === 1'b1 && n < 500) begin
            step(1);
            n++;
        end
        // Seven empty pages scanned, eight clocks each; stop already ate a few
        check("page time", 8'(n >= PAGE_T + 48 && n <= PAGE_T + 64), 8'h01);
    endtask : t_partial

    task automatic t_read();
        logic       k;
        logic [7:0] d;
        open_at({SEL, 12'h7f8});
        m.start();
        m.ctrl({SEL, 12'h000}, 1'b1, k);
        check("read ack", 8'(k), 8'h01);
        // Crosses 0x7ff, wrapped tail, overwritten and kept bytes
        for (int i = 0; i < 18; i++) begin
            m.rbyte(i < 17, d);
            check("seq data", d, exp_mem[32'h7f8 + i]);
        end
        m.stop();
        step(20);
        check("no write", 8'(busy), 8'h00);
        m.start();
        m.ctrl({SEL, 12'h000}, 1'b1, k);
        m.rbyte(1'b0, d);
        check("current addr", d, exp_mem[32'h80a]);
        m.stop();
    endtask : t_read

    initial begin
        rst_n     = 1'b0;
        cs        = SEL;
        bad_count = 0;
        tests_run = 0;
        step(2);
        rst_n = 1'b1;
        step(1);
        check("reset pull", 8'(sda_oe), 8'h00);
        check("reset standby", 8'(standby), 8'h01);
        step(4);
        t_refuse();
        t_cache_write();
        t_partial();
        t_read();
        complete_run();
    end

    // Whole run is near 21k cycles
    initial begin
        #600us;
        bad_count++;
        complete_run();
    end
endmodule : testbench
